//--- core/instr_exec_pkg.sv
// constants, states and helpers shared by the instruction execute block
// assumes one core clock, four clocks per machine cycle
package instr_exec_pkg;
	localparam int unsigned PC_W = 21;
	localparam int unsigned DADDR_W = 12;
	localparam int unsigned STACK_DEPTH = 31;
	localparam logic [20:0] PC_STEP = 21'h000002;
	localparam logic [3:0] OPC_BIT_INVERT = 4'h7;
	localparam logic [3:0] OPC_SKIP_CLR = 4'hb;
	localparam logic [3:0] OPC_SKIP_SET = 4'ha;
	localparam logic [3:0] OPC_JUMP = 4'hd;
	localparam logic [3:0] OPC_BRANCH_HI = 4'he;
	localparam logic [3:0] BR_OVF_SEL = 4'h4;
	localparam logic [2:0] CALL_SEL = 3'h6;
	localparam logic [3:0] WORD2_PREFIX = 4'hf;
	localparam logic [7:0] GOTO_HI = 8'hef;
	localparam logic [7:0] LOADPTR_HI = 8'hee;
	localparam logic [3:0] MOVE_PREFIX = 4'hc;
	localparam logic [15:0] WDT_CLEAR_WORD = 16'h0004;
	localparam logic [7:0] INDEX_LIMIT = 8'h5f;
	localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
	localparam int unsigned OVF_BIT = 3;
	localparam int unsigned EXT_EN_BIT = 0;
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] STATE_OFS = 4'h1;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic TO_RST = 1'b1;
	localparam logic PD_RST = 1'b1;

	typedef enum logic [1:0] {
		Q1 = 2'b00,
		Q2 = 2'b01,
		Q3 = 2'b10,
		Q4 = 2'b11
	} q_phase_type;

	typedef enum logic [2:0] {
		S_RUN = 3'b000,
		S_CALL2 = 3'b001,
		S_SKIP = 3'b010,
		S_SKIP2 = 3'b011,
		S_NOP = 3'b100
	} exec_state_type;

	// first word of any instruction that owns a second word
	function automatic logic two_word_f(input logic [15:0] w);
		return (w[15:9] == {OPC_BRANCH_HI, CALL_SEL}) ||
			(w[15:8] == GOTO_HI) || (w[15:8] == LOADPTR_HI) ||
			(w[15:12] == MOVE_PREFIX);
	endfunction
endpackage

//--- core/q_phase_gen.sv
// quarter-cycle sequencer: four core clocks form one machine cycle
// assumes the core clock runs free from reset release
module q_phase_gen (
	input wire logic sys_clk_i, // core clock
	input wire logic resetn_i, // async reset, active low
	output instr_exec_pkg::q_phase_type q_o // current quarter
);
	import instr_exec_pkg::*;

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			q_o <= Q1;
		end else begin
			unique case (q_o)
				Q1: q_o <= Q2;
				Q2: q_o <= Q3;
				Q3: q_o <= Q4;
				Q4: q_o <= Q1;
			endcase
		end
	end
endmodule

//--- core/operand_address.sv
// file operand address: access bank, banked or indexed literal offset
// assumes the bank and index base are stable while decoding
module operand_address (
	input wire logic [7:0] f_i, // file field
	input wire logic bank_bit_i, // operand bank-select bit
	input wire logic [3:0] bsr_i, // bank select register
	input wire logic ext_en_i, // extended set enabled
	input wire logic [11:0] index_base_i, // index pointer base
	output logic [11:0] addr_o, // data memory address
	output logic indexed_o // indexed mode used
);
	import instr_exec_pkg::*;

	always_comb begin
		indexed_o = ext_en_i && !bank_bit_i && (f_i <= INDEX_LIMIT); // RQ3
		if (indexed_o) begin
			addr_o = index_base_i + {4'h0, f_i}; // RQ3
		end else if (bank_bit_i) begin
			addr_o = {bsr_i, f_i}; // RQ2
		end else if (f_i <= INDEX_LIMIT) begin
			addr_o = {ACCESS_LO_BANK, f_i}; // RQ1
		end else begin
			addr_o = {ACCESS_HI_BANK, f_i}; // RQ1
		end
	end
endmodule

//--- core/bit_branch_call_instr_exec.sv
// bit invert, bit test skips, branches, call and watchdog clear execute
// assumes program memory answers instr_i for pc_o in the same Q1 cycle
// Behaviour
// RQ1: bank bit 0 selects fixed access bank
// RQ2: bank bit 1 uses bank select register
// RQ3: extended set, bit 0, f<=5Fh indexed
// RQ4: bit invert flips chosen bit, one cycle
// RQ5: skip-if-clear discards next word when bit 0
// RQ6: skip-if-set skips when bit 1, no flags
// RQ7: skip costs 1, 2 or 3 cycles
// RQ8: overflow branch only when overflow set
// RQ9: taken target is address plus 2 plus 2n
// RQ10: taken two cycles, not taken one cycle
// RQ11: call pushes own address plus four
// RQ12: fast-save bit copies W, status, bank
// RQ13: call loads 20-bit literal, two cycles
// RQ14: call is two words, second prefix 1111
// RQ15: watchdog clear resets counter, sets flags
// RQ16: relative jump always adds 2n, two cycles
// RQ17: read in Q2, write back in Q4
module bit_branch_call_instr_exec (
	input wire logic sys_clk_i, // core clock, 125 MHz
	input wire logic resetn_i, // async reset, active low
	input wire logic [15:0] instr_i, // program word at pc_o
	output logic fetch_o, // program word taken this cycle
	output logic [instr_exec_pkg::PC_W-1:0] pc_o, // program counter
	output logic [instr_exec_pkg::DADDR_W-1:0] dmem_addr_o, // data address
	output logic dmem_re_o, // data read strobe
	input wire logic [7:0] dmem_rdata_i, // read data, one cycle later
	output logic dmem_we_o, // data write strobe
	output logic [7:0] dmem_wdata_o, // data write value
	input wire logic [7:0] w_i, // working register
	input wire logic [4:0] status_i, // status register
	input wire logic [3:0] bsr_i, // bank select register
	input wire logic [11:0] index_base_i, // index pointer base
	output logic [7:0] working_shadow_o, // working shadow
	output logic [4:0] flags_shadow_o, // status shadow
	output logic [3:0] bank_sel_shadow_o, // bank select shadow
	output logic [instr_exec_pkg::PC_W-1:0] return_stack_top_o, // top
	output logic wdt_clear_o, // clear counter and postscaler
	output logic timeout_flag_o, // timeout status bit
	output logic power_down_flag_o, // power-down status bit
	input wire logic to_clear_i, // watchdog timeout event
	input wire logic pd_clear_i, // sleep entry event
	input wire logic [3:0] reg_addr_i, // register address
	input wire logic [7:0] reg_wdata_i, // register write data
	input wire logic reg_wr_i, // register write strobe
	input wire logic reg_rd_i, // register read strobe
	output logic [7:0] reg_rdata_o // read data, next cycle
);
	import instr_exec_pkg::*;

	q_phase_type q;
	exec_state_type state_r;
	logic [15:0] ir_r;
	logic [7:0] call_lo_r;
	logic [7:0] data_r;
	logic [7:0] ctrl_r;
	logic [4:0] sp_r;
	logic [PC_W-1:0] stack_mem [STACK_DEPTH];
	logic [11:0] op_addr;
	logic op_indexed;
	logic exec;
	logic is_inv;
	logic is_sclr;
	logic is_sset;
	logic is_bitop;
	logic is_bov;
	logic is_jump;
	logic is_call;
	logic is_wdt;
	logic taken;
	logic skip;
	logic sel_bit;
	logic [7:0] bit_mask;
	logic [PC_W-1:0] br_ofs;
	logic [PC_W-1:0] jump_ofs;

	q_phase_gen u_q (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.q_o(q)
	);

	// address is worked out from the raw word so it is ready by Q2
	operand_address u_addr (
		.f_i(instr_i[7:0]),
		.bank_bit_i(instr_i[8]),
		.bsr_i(bsr_i),
		.ext_en_i(ctrl_r[EXT_EN_BIT]),
		.index_base_i(index_base_i),
		.addr_o(op_addr),
		.indexed_o(op_indexed)
	);

	assign exec = (state_r == S_RUN);
	assign is_inv = exec && (ir_r[15:12] == OPC_BIT_INVERT);
	assign is_sclr = exec && (ir_r[15:12] == OPC_SKIP_CLR);
	assign is_sset = exec && (ir_r[15:12] == OPC_SKIP_SET);
	assign is_bitop = is_inv || is_sclr || is_sset;
	assign is_bov = exec && (ir_r[15:8] == {OPC_BRANCH_HI, BR_OVF_SEL});
	assign is_jump = exec && (ir_r[15:12] == OPC_JUMP);
	assign is_call = exec && (ir_r[15:9] == {OPC_BRANCH_HI, CALL_SEL});
	assign is_wdt = exec && (ir_r == WDT_CLEAR_WORD);
	assign bit_mask = 8'h01 << ir_r[11:9];
	assign sel_bit = |(data_r & bit_mask);
	assign taken = (is_bov && status_i[OVF_BIT]) || is_jump; // RQ8 RQ16
	assign skip = (is_sclr && !sel_bit) || (is_sset && sel_bit); // RQ5 RQ6
	assign br_ofs = {{12{ir_r[7]}}, ir_r[7:0], 1'b0};
	assign jump_ofs = {{9{ir_r[10]}}, ir_r[10:0], 1'b0};
	// a branch-caused dead cycle does not fetch; skipped words are fetched
	assign fetch_o = (q == Q1) && (state_r != S_NOP);
	assign dmem_re_o = (q == Q2) && is_bitop; // RQ17

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ir_r <= 16'h0000;
		end else if (fetch_o) begin
			ir_r <= instr_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_r <= S_RUN;
		end else if (q == Q4) begin
			unique case (state_r)
				S_RUN: begin
					if (taken) begin
						state_r <= S_NOP; // RQ10 RQ16
					end else if (is_call) begin
						state_r <= S_CALL2; // RQ13
					end else if (skip) begin
						state_r <= S_SKIP; // RQ5 RQ7
					end else begin
						state_r <= S_RUN;
					end
				end
				S_SKIP: begin
					// a discarded two-word instruction costs one more dead cycle
					state_r <= two_word_f(ir_r) ? S_SKIP2 : S_RUN; // RQ7
				end
				S_CALL2: state_r <= S_RUN;
				S_SKIP2: state_r <= S_RUN;
				S_NOP: state_r <= S_RUN;
				default: state_r <= S_RUN;
			endcase
		end
	end

	// pc has already stepped past the fetched word when the branch resolves
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pc_o <= '0;
		end else if (fetch_o) begin
			pc_o <= pc_o + PC_STEP;
		end else if (q == Q4 && taken) begin
			pc_o <= pc_o + (is_jump ? jump_ofs : br_ofs); // RQ9 RQ16
		end else if (q == Q4 && state_r == S_CALL2) begin
			pc_o <= {ir_r[11:0], call_lo_r, 1'b0}; // RQ13 RQ14
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			call_lo_r <= 8'h00;
		end else if (q == Q2 && is_call) begin
			call_lo_r <= ir_r[7:0]; // RQ14
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dmem_addr_o <= '0;
		end else if (fetch_o) begin
			dmem_addr_o <= op_addr; // RQ1 RQ2 RQ3
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			data_r <= 8'h00;
			dmem_we_o <= 1'b0;
			dmem_wdata_o <= 8'h00;
		end else begin
			if (q == Q3 && is_bitop) begin
				data_r <= dmem_rdata_i;
			end
			dmem_we_o <= (q == Q3) && is_inv; // RQ4 RQ17
			if (q == Q3 && is_inv) begin
				dmem_wdata_o <= dmem_rdata_i ^ bit_mask; // RQ4
			end
		end
	end

	// return address: pc is at call+2 during Q3, one more step gives call+4
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sp_r <= 5'h00;
			return_stack_top_o <= '0;
		end else if (q == Q3 && is_call) begin
			return_stack_top_o <= pc_o + PC_STEP; // RQ11
			// overflow keeps the last entry rather than wrapping
			if (sp_r < 5'(STACK_DEPTH)) begin
				sp_r <= sp_r + 5'h01;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (q == Q3 && is_call && sp_r < 5'(STACK_DEPTH)) begin
			stack_mem[sp_r] <= pc_o + PC_STEP; // RQ11
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			working_shadow_o <= 8'h00;
			flags_shadow_o <= 5'h00;
			bank_sel_shadow_o <= 4'h0;
		end else if (q == Q3 && is_call && ir_r[8]) begin
			working_shadow_o <= w_i; // RQ12
			flags_shadow_o <= status_i; // RQ12
			bank_sel_shadow_o <= bsr_i; // RQ12
		end
	end

	// the flags are set here and cleared by timeout or sleep; set wins
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wdt_clear_o <= 1'b0;
			timeout_flag_o <= TO_RST;
			power_down_flag_o <= PD_RST;
		end else begin
			wdt_clear_o <= (q == Q4) && is_wdt; // RQ15
			if (wdt_clear_o) begin
				timeout_flag_o <= 1'b1; // RQ15
				power_down_flag_o <= 1'b1; // RQ15
			end else begin
				if (to_clear_i) begin
					timeout_flag_o <= 1'b0;
				end
				if (pd_clear_i) begin
					power_down_flag_o <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_r <= CTRL_RST;
		end else if (reg_wr_i && reg_addr_i == CTRL_OFS) begin
			ctrl_r <= {7'h00, reg_wdata_i[EXT_EN_BIT]};
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i && reg_addr_i == CTRL_OFS) begin
			reg_rdata_o <= ctrl_r;
		end else if (reg_rd_i && reg_addr_i == STATE_OFS) begin
			reg_rdata_o <= {sp_r, state_r == S_RUN, power_down_flag_o,
				timeout_flag_o};
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end

	a_access_bank: assert property ( // RQ1
		@(posedge sys_clk_i) disable iff (!resetn_i)
		fetch_o && !instr_i[8] && !ctrl_r[EXT_EN_BIT] |=>
		dmem_addr_o[11:8] == (($past(instr_i[7:0]) <= INDEX_LIMIT) ?
			ACCESS_LO_BANK : ACCESS_HI_BANK))
		else $error("access bank address wrong");

	a_banked_addr: assert property ( // RQ2
		@(posedge sys_clk_i) disable iff (!resetn_i)
		fetch_o && instr_i[8] |=>
		dmem_addr_o == {$past(bsr_i), $past(instr_i[7:0])})
		else $error("banked address wrong");

	a_indexed_addr: assert property ( // RQ3
		@(posedge sys_clk_i) disable iff (!resetn_i)
		fetch_o && !instr_i[8] && ctrl_r[EXT_EN_BIT] &&
		instr_i[7:0] <= INDEX_LIMIT |=>
		dmem_addr_o == $past(index_base_i) + {4'h0, $past(instr_i[7:0])})
		else $error("indexed address wrong");

	a_invert_write: assert property ( // RQ4
		@(posedge sys_clk_i) disable iff (!resetn_i)
		dmem_re_o && is_inv |=> ##1 dmem_we_o &&
		dmem_wdata_o == ($past(dmem_rdata_i) ^ bit_mask))
		else $error("bit invert write wrong");

	a_skip_decision: assert property ( // RQ5
		@(posedge sys_clk_i) disable iff (!resetn_i)
		q == Q4 && (is_sclr || is_sset) && !taken |=>
		(state_r == S_SKIP) == $past(skip))
		else $error("skip decision wrong");

	a_skip_length: assert property ( // RQ7
		@(posedge sys_clk_i) disable iff (!resetn_i)
		state_r == S_SKIP && q == Q4 |=>
		(state_r == S_SKIP2) == two_word_f($past(ir_r)) ##4 state_r == S_RUN)
		else $error("skip length wrong");

	a_branch_target: assert property ( // RQ9
		@(posedge sys_clk_i) disable iff (!resetn_i)
		q == Q4 && is_bov && status_i[OVF_BIT] |=>
		pc_o == $past(pc_o) + $past(br_ofs) && state_r == S_NOP
		##4 state_r == S_RUN)
		else $error("branch target wrong");

	a_not_taken: assert property ( // RQ10
		@(posedge sys_clk_i) disable iff (!resetn_i)
		q == Q4 && is_bov && !status_i[OVF_BIT] |=>
		pc_o == $past(pc_o) && state_r == S_RUN)
		else $error("untaken branch moved pc");

	a_call_push: assert property ( // RQ11
		@(posedge sys_clk_i) disable iff (!resetn_i)
		q == Q3 && is_call |=>
		return_stack_top_o == $past(pc_o) + PC_STEP ##5
		pc_o == {ir_r[11:0], $past(ir_r[7:0], 6), 1'b0})
		else $error("call push or target wrong");

	a_wdt_flags: assert property ( // RQ15
		@(posedge sys_clk_i) disable iff (!resetn_i)
		q == Q4 && is_wdt |=> wdt_clear_o ##1
		timeout_flag_o && power_down_flag_o)
		else $error("watchdog clear flags wrong");
endmodule

//--- test/mem_model.sv
// program and data memory on the far side of the execute block
// assumes one clock; the bench fills pm and dm before reset release
module mem_model (
	input wire logic clk_i, // core clock
	input wire logic fetch_i, // word taken this cycle
	input wire logic [20:0] pc_i, // program address
	output logic [15:0] instr_o, // program word
	input wire logic [11:0] addr_i, // data address
	input wire logic re_i, // data read strobe
	input wire logic we_i, // data write strobe
	input wire logic [7:0] wdata_i, // write value
	output logic [7:0] rdata_o // read value, next cycle
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] pm [0:31];
	logic [7:0] dm [0:4095];
	logic [15:0] junk_r = 16'h5a5a;
	initial rdata_o = 8'h00;
	// outside a fetch the word is noise, never a stale copy
	assign instr_o = fetch_i ? pm[pc_i[5:1]] : junk_r;
	always @(posedge clk_i) begin
		junk_r <= ~junk_r ^ 16'h0101;
		rdata_o <= re_i ? dm[addr_i] : ~rdata_o;
		if (we_i)
			dm[addr_i] <= wdata_i;
	end
endmodule

//--- test/tb.sv
// self-checking bench: reference model of fetches, writes and calls
// assumes mem_model answers fetches and data reads
`define CHK(got, exp, msg) begin \
	compares++; \
	if ((got) !== (exp)) begin \
		n_mismatch++; \
		$display("MISMATCH %0t %s", $time, msg); \
	end \
end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import instr_exec_pkg::*;
	logic sys_clk_i = 0, resetn_i = 0;
	logic [15:0] instr;
	logic [20:0] pc, return_stack_top;
	logic [11:0] daddr, ib = 0;
	logic fetch, dre, dwe, wclr, tof, pdf;
	logic [7:0] dwd, drd, ws, rdat, w = 0, rwd = 0;
	logic [4:0] fs, st = 0;
	logic [3:0] bs, bank_select_reg = 0, ra = 0;
	logic toc = 0, pdc = 0, rwr = 0, rrd = 0;
	int n_mismatch = 0, compares = 0, ecnt = 0, wcnt = 0, tick = 0;
	int etos, ewdt;
	int qpc[$], qmc[$], qwa[$], qwd[$];
	logic [15:0] seed = 16'h0025;
	logic [15:0] prog [0:31];
	logic [7:0] rdm [0:4095];

	bit_branch_call_instr_exec i_bit_branch_call_instr_exec (
		.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .instr_i(instr),
		.fetch_o(fetch), .pc_o(pc), .dmem_addr_o(daddr), .dmem_re_o(dre),
		.dmem_rdata_i(drd), .dmem_we_o(dwe), .dmem_wdata_o(dwd),
		.w_i(w), .status_i(st), .bsr_i(bank_select_reg), .index_base_i(ib),
		.working_shadow_o(ws), .flags_shadow_o(fs),
		.bank_sel_shadow_o(bs), .return_stack_top_o(return_stack_top),
		.wdt_clear_o(wclr), .timeout_flag_o(tof),
		.power_down_flag_o(pdf), .to_clear_i(toc), .pd_clear_i(pdc),
		.reg_addr_i(ra), .reg_wdata_i(rwd), .reg_wr_i(rwr),
		.reg_rd_i(rrd), .reg_rdata_o(rdat));
	mem_model i_mem_model (
		.clk_i(sys_clk_i), .fetch_i(fetch), .pc_i(pc), .instr_o(instr),
		.addr_i(daddr), .re_i(dre), .we_i(dwe), .wdata_i(dwd),
		.rdata_o(drd));

	always #4 sys_clk_i = ~sys_clk_i;

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic int ea(input int f, input int bb, input int ext);
		if (bb)
			return bank_select_reg * 256 + f;
		if (ext && f <= 95)
			return (ib + f) % 4096;
		return f <= 95 ? f : 3840 + f;
	endfunction

	task automatic summarize();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// reference run of the program, fetch by fetch
	task automatic model(input int ext, input logic ovf);
		int p, m, sk, a, nw;
		logic [15:0] wd;
		p = 0; m = 0; sk = 0; etos = 0; ewdt = 0;
		while (qpc.size() < 24) begin
			wd = prog[p / 2];
			qpc.push_back(p);
			qmc.push_back(m);
			nw = p + 2;
			m++;
			a = ea(wd[7:0], wd[8], ext);
			if (sk > 0)
				sk--;
			else case (wd[15:12])
				4'h7: begin
					rdm[a] ^= 8'h01 << wd[11:9];
					qwa.push_back(a);
					qwd.push_back(rdm[a]);
				end
				4'ha, 4'hb: if (rdm[a][wd[11:9]] != wd[12])
					sk = (prog[p / 2 + 1][15:9] == 7'h76) ? 2 : 1;
				4'hd: begin
					nw = p + 2 + 2 * int'($signed(wd[10:0]));
					m++;
				end
				4'he: if (wd[11:8] == 4'h4) begin
					if (ovf) begin
						nw = p + 2 + 2 * int'($signed(wd[7:0]));
						m++;
					end
				end else begin
					qpc.push_back(p + 2);
					qmc.push_back(m);
					m++;
					etos = p + 4;
					nw = 2 * {prog[p / 2 + 1][11:0], wd[7:0]};
				end
				4'h0: if (wd == 16'h0004)
					ewdt++;
				default: ;
			endcase
			p = nw;
		end
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		ra <= a;
		rwd <= d;
		rwr <= 1'b1;
		@(posedge sys_clk_i);
		rwr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [3:0] a, input int e);
		@(posedge sys_clk_i);
		ra <= a;
		rrd <= 1'b1;
		@(posedge sys_clk_i);
		rrd <= 1'b0;
		#1 `CHK(rdat, e, "register read")
	endtask

	task automatic run(input int ext, input logic ovf);
		int i, a;
		@(posedge sys_clk_i);
		resetn_i <= 1'b0;
		seed = lfsr(seed);
		w <= seed[7:0];
		st <= {seed[12], ovf, seed[10:8]};
		bank_select_reg <= seed[15:12];
		ib <= seed[11:0];
		for (i = 0; i < 4096; i++) begin
			seed = lfsr(seed);
			i_mem_model.dm[i] = seed[7:0];
			rdm[i] = seed[7:0];
		end
		i_mem_model.pm = prog;
		repeat (8) @(posedge sys_clk_i);
		// force the first bit test to skip the two-word call
		a = ea(16, 0, ext);
		i_mem_model.dm[a][3] = 1'b1;
		rdm[a][3] = 1'b1;
		model(ext, ovf);
		wcnt = 0;
		resetn_i <= 1'b1;
		reg_wr(CTRL_OFS, ext);
		reg_rd(CTRL_OFS, ext);
		reg_rd(4'h7, 0);
		reg_rd(STATE_OFS, 8'h07);
		@(posedge sys_clk_i);
		toc <= 1'b1;
		pdc <= 1'b1;
		@(posedge sys_clk_i);
		toc <= 1'b0;
		pdc <= 1'b0;
		@(posedge sys_clk_i);
		#1 `CHK(tof, 1'b0, "timeout flag cleared")
		`CHK(pdf, 1'b0, "power-down flag cleared")
		i = 0;
		while (qpc.size() > 0 && i < 400) begin
			@(posedge sys_clk_i);
			i++;
		end
		#1 `CHK(qpc.size(), 0, "fetches left")
		`CHK(qwa.size(), 0, "writes left")
		`CHK(return_stack_top, etos, "return address")
		`CHK(ws, w, "working shadow")
		`CHK(fs, st, "status shadow")
		`CHK(bs, bank_select_reg, "bank shadow")
		`CHK(wcnt, ewdt, "watchdog clears")
		`CHK({tof, pdf}, 2'b11, "watchdog flags")
		$display("test pass ext=%0d done", ext);
	endtask

	always @(posedge sys_clk_i) begin
		tick++;
		if (!resetn_i)
			ecnt = 0;
		else begin
			if (fetch === 1'b1 && qpc.size() > 0) begin
				`CHK(pc, qpc.pop_front(), "fetch address")
				`CHK(ecnt, 4 * qmc.pop_front(), "fetch cycle")
			end
			if (dwe === 1'b1) begin
				`CHK(qwa.size() > 0, 1'b1, "extra write")
				if (qwa.size() > 0) begin
					`CHK(daddr, qwa.pop_front(), "write address")
					`CHK(dwd, qwd.pop_front(), "write value")
				end
			end
			if (wclr === 1'b1)
				wcnt++;
			ecnt++;
		end
		// ceiling well above two passes of some 140 cycles each
		if (tick > 6000) begin
			n_mismatch++;
			$display("MISMATCH %0t run too long", $time);
			summarize();
		end
	end

	initial begin
		prog = '{2: 16'h7610, 3: 16'hb610, 4: 16'hec05, 5: 16'hf000,
			6: 16'ha710, 7: 16'h7f80, 8: 16'h7ea0, 9: 16'he402,
			10: 16'h7070, 12: 16'hed0e, 13: 16'hf000, 14: 16'h0004,
			15: 16'hd7ff, default: 16'h0000};
		run(1, 1'b1);
		run(0, 1'b0);
		summarize();
	end
endmodule
